// ==== src/wsc_top.sv ====
module wsc_top (
  input wire logic i_clock, // System clock, 250 MHz
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [9:0] i_io_addr, // I/O address pins
  input wire logic i_io_read_n, // I/O read strobe
  input wire logic i_io_write_n, // I/O write strobe
  input wire logic i_byte_high_n, // Byte high enable
  input wire logic [7:0] i_io_data, // Data bus input
  output logic [7:0] o_io_data, // Data bus output
  output logic o_io_data_oe_n, // Data bus drive enable
  input wire logic i_irq3, // Interrupt line 3 pin
  input wire logic i_irq4, // Interrupt line 4 pin
  input wire logic i_irq8, // Clock interrupt line 8 pin
  input wire logic i_irq6, // Floppy interrupt pin
  input wire logic i_irq14, // Hard disk interrupt pin
  input wire logic i_external_trap_pin_n, // External trap pin, loads the cycle capture only
  input wire logic i_battery_low_input_n, // Battery low pin
  input wire logic i_suspend_resume_input_n, // Suspend/resume pin
  input wire logic i_ring_indicate, // Serial port ring indicate
  input wire logic i_system_asleep, // Power manager asleep level
  input wire logic i_sleep_entry, // Pulse on sleep or suspend entry
  input wire logic i_power_mode_change, // Pulse on mode change
  input wire logic i_tick_irq_request, // Pulse from timer 0 SMI logic
  input wire logic i_interrupt_reload_enable, // Disk interrupt reload
  input wire logic [7:0] i_window_base, // Window address bits 9 to 2
  input wire logic [1:0] i_window_range, // Window size code
  input wire logic [2:0][wsc_pkg::PERIOD_W-1:0] i_idle_period, // Timer periods
  output logic o_wake, // Wake pulse to power manager
  output logic o_smi_request, // SMI request to CPU core
  output logic [2:0] o_device_idle // Idle timer expired per device
);
  wsc_pkg::wsc_bus_t bus;
  wsc_pkg::wsc_state_t state;
  wsc_pkg::wsc_cycle_t capture;
  logic [4:0] irq_sync, irq_prev;
  logic [2:0] low_sync, low_prev;
  logic read_n_prev, write_n_prev, ring_prev;
  logic read_start, read_end, write_start, write_end, access;
  logic cfg_write;
  logic [7:0] cfg_index, wake_mask, wake_cause, boot_reserved;
  logic [7:0] latches, trap_enables, trap_flags, next_trap_flags;
  logic [4:0] hit, trap;
  logic [2:0] armed, enable_prev, expired, reload;
  logic [3:0] wake_event, wake_set;
  logic external_event, power_event;
  logic [7:0] read_value;
  logic read_mapped;

  // Decoded address match with don't-care bits
  function automatic logic in_range(input logic [9:0] addr, input logic [9:0] base,
                                    input logic [9:0] span);
    in_range = (addr & ~span) == (base & ~span);
  endfunction

  // Don't-care bits of the window for each size code
  function automatic logic [9:0] window_span(input logic [1:0] code);
    case (code)
      2'h0: window_span = 10'h003;
      2'h1: window_span = 10'h007;
      2'h2: window_span = 10'h00F;
      default: window_span = 10'h01F;
    endcase
  endfunction

  // Pins cross into the clock domain
  wsc_sync #(.WIDTH(21), .RESET_VALUE(wsc_pkg::BUS_PIN_IDLE)) u_bus_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async({i_io_addr, i_io_read_n, i_io_write_n, i_byte_high_n, i_io_data}),
    .o_sync(bus)
  );
  wsc_sync #(.WIDTH(5), .RESET_VALUE(5'h00)) u_irq_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async({i_irq14, i_irq6, i_irq8, i_irq4, i_irq3}),
    .o_sync(irq_sync)
  );
  wsc_sync #(.WIDTH(3), .RESET_VALUE(wsc_pkg::LOW_PIN_IDLE)) u_low_sync (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async({i_external_trap_pin_n, i_battery_low_input_n, i_suspend_resume_input_n}),
    .o_sync(low_sync)
  );

  // Previous levels for edge detection
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_prev <= 5'h00;
      low_prev <= wsc_pkg::LOW_PIN_IDLE;
      read_n_prev <= 1'b1;
      write_n_prev <= 1'b1;
      ring_prev <= 1'b0;
      enable_prev <= 3'h0;
    end else begin
      irq_prev <= irq_sync;
      low_prev <= low_sync;
      read_n_prev <= bus.read_n;
      write_n_prev <= bus.write_n;
      ring_prev <= i_ring_indicate;
      enable_prev <= trap_enables[2:0];
    end
  end

  // Strobe edges and pin events
  assign read_start = read_n_prev & ~bus.read_n;
  assign read_end = ~read_n_prev & bus.read_n;
  assign write_start = write_n_prev & ~bus.write_n;
  assign write_end = ~write_n_prev & bus.write_n;
  assign access = read_start | write_start;
  assign external_event = low_prev[2] & ~low_sync[2];
  assign power_event = i_power_mode_change | (low_prev[1] & ~low_sync[1]) |
                       (low_prev[0] & ~low_sync[0]);
  assign cfg_write = write_end && (state == wsc_pkg::WSC_ST_WRITE) &&
                     (bus.addr == wsc_pkg::CFG_DATA_PORT);

  assign hit[wsc_pkg::HARDDISK_BIT] = in_range(bus.addr, wsc_pkg::HARDDISK_BASE,
                                               wsc_pkg::HARDDISK_SPAN);
  assign hit[wsc_pkg::FLOPPY_BIT] = in_range(bus.addr, wsc_pkg::FLOPPY_BASE,
                                             wsc_pkg::FLOPPY_SPAN);
  assign hit[wsc_pkg::WINDOW_BIT] = in_range(bus.addr, {i_window_base, 2'h0},
                                             window_span(i_window_range));
  assign hit[wsc_pkg::KEYBOARD_BIT] = in_range(bus.addr, wsc_pkg::KEYBOARD_BASE,
                                               wsc_pkg::KEYBOARD_SPAN);
  assign hit[wsc_pkg::CLOCK_RANGE_BIT] = in_range(bus.addr, wsc_pkg::CLOCK_RANGE_BASE,
                                                  wsc_pkg::CLOCK_RANGE_SPAN);

  // Per timed device: trap decision, arming and idle timer
  genvar g;
  generate
    for (g = 0; g < wsc_pkg::NUM_TIMED; g++) begin : g_timed
      assign trap[g] = access & hit[g] & trap_enables[g] & ~latches[g] & armed[g];

      if (g == wsc_pkg::HARDDISK_BIT) begin : g_hd
        assign reload[g] = (access & hit[g]) | (i_interrupt_reload_enable & irq_sync[4]);
      end else if (g == wsc_pkg::FLOPPY_BIT) begin : g_fd
        assign reload[g] = (access & hit[g]) | (i_interrupt_reload_enable & irq_sync[3]);
      end else begin : g_win
        assign reload[g] = access & hit[g];
      end

      wsc_idle_timer u_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_period(i_idle_period[g]),
        .i_reload(reload[g]),
        .o_expired(expired[g])
      );

      // arming events, set wins over the trap
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          armed[g] <= 1'b0;
        end else if ((trap_enables[g] & ~enable_prev[g]) | expired[g] | i_sleep_entry |
                     (cfg_write && cfg_index == wsc_pkg::IDX_DEVICE_TIMEOUT_LATCHES &&
                      !bus.data[g])) begin
          armed[g] <= 1'b1;
        end else if (trap[g]) begin
          armed[g] <= 1'b0;
        end
      end

      // Idle indication follows the timer
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          o_device_idle[g] <= 1'b0;
        end else if (expired[g]) begin
          o_device_idle[g] <= 1'b1;
        end else if (reload[g]) begin
          o_device_idle[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // untimed ranges trap on every enabled access
  assign trap[wsc_pkg::KEYBOARD_BIT] = access & hit[wsc_pkg::KEYBOARD_BIT] &
                                       trap_enables[wsc_pkg::KEYBOARD_BIT];
  assign trap[wsc_pkg::CLOCK_RANGE_BIT] = access & hit[wsc_pkg::CLOCK_RANGE_BIT] &
                                          trap_enables[wsc_pkg::CLOCK_RANGE_BIT];

  assign wake_event = {i_ring_indicate & ~ring_prev, irq_sync[2] & ~irq_prev[2],
                       irq_sync[1] & ~irq_prev[1], irq_sync[0] & ~irq_prev[0]};
  assign wake_set = i_system_asleep ? (wake_event & ~wake_mask[5:2]) : 4'h0;

  // Bus slave sequencing
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state <= wsc_pkg::WSC_ST_IDLE;
    end else begin
      case (state)
        wsc_pkg::WSC_ST_IDLE: begin
          if (read_start && read_mapped) begin
            state <= wsc_pkg::WSC_ST_READ;
          end else if (write_start && (bus.addr == wsc_pkg::CFG_ADDR_PORT ||
                                       bus.addr == wsc_pkg::CFG_DATA_PORT)) begin
            state <= wsc_pkg::WSC_ST_WRITE;
          end
        end
        wsc_pkg::WSC_ST_READ: begin
          if (read_end) begin
            state <= wsc_pkg::WSC_ST_IDLE;
          end
        end
        wsc_pkg::WSC_ST_WRITE: begin
          if (write_end) begin
            state <= wsc_pkg::WSC_ST_IDLE;
          end
        end
        default: state <= wsc_pkg::WSC_ST_IDLE;
      endcase
    end
  end

  // Read selection for the current index
  always_comb begin
    read_value = 8'h00;
    read_mapped = 1'b1;
    if (bus.addr == wsc_pkg::CFG_ADDR_PORT) begin
      read_value = cfg_index;
    end else if (bus.addr != wsc_pkg::CFG_DATA_PORT) begin
      read_mapped = 1'b0;
    end else begin
      case (cfg_index)
        wsc_pkg::IDX_WAKE_SOURCE_MASK: read_value = wake_mask;
        wsc_pkg::IDX_WAKE_CAUSE_RECORD: read_value = wake_cause;
        wsc_pkg::IDX_BOOT_RESERVED: read_value = boot_reserved;
        wsc_pkg::IDX_DEVICE_TIMEOUT_LATCHES: read_value = latches;
        wsc_pkg::IDX_ACCESS_TRAP_ENABLES: read_value = trap_enables;
        wsc_pkg::IDX_TRAPPED_CYCLE_CAPTURE: read_value = capture;
        wsc_pkg::IDX_TRAP_SOURCE_FLAGS: read_value = trap_flags;
        default: read_mapped = 1'b0;
      endcase
    end
  end

  // Data bus drive, held for the whole read strobe
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_io_data <= 8'h00;
      o_io_data_oe_n <= 1'b1;
    end else if (state == wsc_pkg::WSC_ST_IDLE && read_start && read_mapped) begin
      o_io_data <= read_value;
      o_io_data_oe_n <= 1'b0;
    end else if (state == wsc_pkg::WSC_ST_READ && read_end) begin
      o_io_data_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cfg_index <= wsc_pkg::RESET_BYTE;
    end else if (write_end && state == wsc_pkg::WSC_ST_WRITE &&
                 bus.addr == wsc_pkg::CFG_ADDR_PORT) begin
      cfg_index <= bus.data;
    end
  end

  // Plain read/write registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wake_mask <= wsc_pkg::RESET_BYTE;
      boot_reserved <= wsc_pkg::RESET_BYTE;
      trap_enables <= wsc_pkg::RESET_BYTE;
    end else if (cfg_write) begin
      if (cfg_index == wsc_pkg::IDX_WAKE_SOURCE_MASK) begin
        wake_mask <= bus.data;
      end
      if (cfg_index == wsc_pkg::IDX_BOOT_RESERVED) begin
        boot_reserved <= bus.data;
      end
      if (cfg_index == wsc_pkg::IDX_ACCESS_TRAP_ENABLES) begin
        trap_enables <= bus.data;
      end
    end
  end

  // zero write clears, new cause wins
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wake_cause <= wsc_pkg::RESET_BYTE;
    end else if (cfg_write && cfg_index == wsc_pkg::IDX_WAKE_CAUSE_RECORD) begin
      wake_cause <= bus.data | {2'h0, wake_set, 2'h0};
    end else begin
      wake_cause <= wake_cause | {2'h0, wake_set, 2'h0};
    end
  end

  // zero clears a latch bit, one leaves it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      latches <= wsc_pkg::RESET_BYTE;
    end else if (cfg_write && cfg_index == wsc_pkg::IDX_DEVICE_TIMEOUT_LATCHES) begin
      latches <= {bus.data[7:3], (latches[2:0] & bus.data[2:0]) | trap[2:0]};
    end else begin
      latches <= {latches[7:3], latches[2:0] | trap[2:0]};
    end
  end

  // capture on trap or pin event
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      capture <= wsc_pkg::RESET_BYTE;
    end else if ((|trap) | external_event) begin
      capture <= {4'h0, ~bus.write_n, ~bus.read_n, bus.byte_high_n, bus.addr[0]};
    end
  end

  always_comb begin
    next_trap_flags = {1'b0, i_tick_irq_request, power_event, trap};
    if (!(cfg_write && cfg_index == wsc_pkg::IDX_TRAP_SOURCE_FLAGS)) begin
      next_trap_flags = next_trap_flags | trap_flags;
    end
    next_trap_flags = next_trap_flags & wsc_pkg::TRAP_FLAG_FIELD_MASK;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      trap_flags <= wsc_pkg::RESET_BYTE;
    end else begin
      trap_flags <= next_trap_flags;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_smi_request <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_smi_request <= |next_trap_flags;
      o_wake <= |wake_set;
    end
  end
endmodule

// ==== include/wsc_pkg.sv ====
package wsc_pkg;
  // Configuration port addresses on the I/O bus
  localparam logic [9:0] CFG_ADDR_PORT = 10'h022;
  localparam logic [9:0] CFG_DATA_PORT = 10'h023;
  // Index of each register behind the data port
  localparam logic [7:0] IDX_WAKE_SOURCE_MASK = 8'h08;
  localparam logic [7:0] IDX_WAKE_CAUSE_RECORD = 8'h09;
  localparam logic [7:0] IDX_BOOT_RESERVED = 8'h0F;
  localparam logic [7:0] IDX_DEVICE_TIMEOUT_LATCHES = 8'h40;
  localparam logic [7:0] IDX_ACCESS_TRAP_ENABLES = 8'h41;
  localparam logic [7:0] IDX_TRAPPED_CYCLE_CAPTURE = 8'h42;
  localparam logic [7:0] IDX_TRAP_SOURCE_FLAGS = 8'h43;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Wake source bit positions
  localparam int LINE3_WAKE_BIT = 2;
  localparam int RING_WAKE_BIT = 5;
  localparam logic [7:0] WAKE_FIELD_MASK = 8'h3C;
  // Trap source flag bit positions
  localparam int HARDDISK_BIT = 0;
  localparam int FLOPPY_BIT = 1;
  localparam int WINDOW_BIT = 2;
  localparam int KEYBOARD_BIT = 3;
  localparam int CLOCK_RANGE_BIT = 4;
  localparam int POWER_EVENT_BIT = 5;
  localparam int TICK_IRQ_BIT = 6;
  localparam int NUM_TRAPS = 5;
  localparam int NUM_TIMED = 3;
  localparam logic [7:0] TRAP_FLAG_FIELD_MASK = 8'h7F;
  // Decoded I/O ranges: base and don't-care bits
  localparam logic [9:0] HARDDISK_BASE = 10'h1F0;
  localparam logic [9:0] HARDDISK_SPAN = 10'h007;
  localparam logic [9:0] FLOPPY_BASE = 10'h3F0;
  localparam logic [9:0] FLOPPY_SPAN = 10'h007;
  localparam logic [9:0] CLOCK_RANGE_BASE = 10'h070;
  localparam logic [9:0] CLOCK_RANGE_SPAN = 10'h00F;
  localparam logic [9:0] KEYBOARD_BASE = 10'h060;
  localparam logic [9:0] KEYBOARD_SPAN = 10'h004;
  localparam int PERIOD_W = 32;
  // Reset levels of the synchronised pin groups
  localparam logic [20:0] BUS_PIN_IDLE = 21'h000700;
  localparam logic [2:0] LOW_PIN_IDLE = 3'h7;

  typedef enum logic [2:0] {
    WSC_ST_IDLE = 3'b001,
    WSC_ST_READ = 3'b010,
    WSC_ST_WRITE = 3'b100
  } wsc_state_t;

  typedef struct packed {
    logic [9:0] addr;
    logic read_n;
    logic write_n;
    logic byte_high_n;
    logic [7:0] data;
  } wsc_bus_t;

  typedef struct packed {
    logic [3:0] unused;
    logic write_active;
    logic read_active;
    logic byte_high_n;
    logic addr0;
  } wsc_cycle_t;
endpackage

// ==== src/wsc_sync.sv ====
module wsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clock, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] i_async, // Pin levels
  output logic [WIDTH-1:0] o_sync // Levels safe to use
);
  logic [WIDTH-1:0] meta;

  // Two flip-flops; the first is read only by the second
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ==== src/wsc_idle_timer.sv ====
module wsc_idle_timer (
  input wire logic i_clock, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic [wsc_pkg::PERIOD_W-1:0] i_period, // Period in cycles
  input wire logic i_reload, // Restart the period
  output logic o_expired // One-cycle pulse at expiry
);
  logic [wsc_pkg::PERIOD_W-1:0] count;
  logic running;

  // Down counter, stops after expiry until reloaded
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      count <= '0;
      running <= 1'b0;
      o_expired <= 1'b0;
    end else if (i_reload) begin
      count <= i_period;
      running <= 1'b1;
      o_expired <= 1'b0;
    end else if (running && count <= {{(wsc_pkg::PERIOD_W-1){1'b0}}, 1'b1}) begin
      count <= '0;
      running <= 1'b0;
      o_expired <= 1'b1;
    end else begin
      count <= running ? count - 1'b1 : count;
      o_expired <= 1'b0;
    end
  end
endmodule

// ==== testbench/wsc_top_chk.sv ====
module wsc_top_chk (
  input wire logic i_clock, // System clock
  input wire logic i_reset, // Synchronous reset
  input wire logic i_io_read_n, // Read strobe pin
  input wire logic i_io_write_n, // Write strobe pin
  input wire logic i_tick_irq_request, // Timer 0 request
  input wire logic i_power_mode_change, // Mode change pulse
  input wire logic i_system_asleep, // Asleep level
  input wire logic [7:0] o_io_data, // Data bus output
  input wire logic o_io_data_oe_n, // Drive enable
  input wire logic o_wake, // Wake pulse
  input wire logic o_smi_request, // SMI request
  input wire logic [2:0] o_device_idle // Idle per device
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  int unsigned rd_gap;
  int unsigned wr_gap;
  // Cycles since each strobe pin was last low
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_io_read_n) rd_gap <= 0;
    else if (rd_gap < 99) rd_gap <= rd_gap + 1;
  end
  always_ff @(posedge i_clock) begin
    if (!i_io_write_n) wr_gap <= 0;
    else if (i_reset) wr_gap <= 99;
    else if (wr_gap < 99) wr_gap <= wr_gap + 1;
  end
  // Request seen a few cycles after its cause
  sequence s_smi_soon;
    ##[1:3] o_smi_request;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    i_reset |=> !o_wake && !o_smi_request && o_io_data_oe_n && o_device_idle == 3'h0)
    else $error("outputs not quiet after reset");
  a_wake_single: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  a_wake_asleep: assert property (o_wake |-> $past(i_system_asleep))
    else $error("wake while awake");
  a_tick_smi: assert property (i_tick_irq_request |-> s_smi_soon)
    else $error("tick request gave no smi");
  a_power_smi: assert property (i_power_mode_change |-> s_smi_soon)
    else $error("mode change gave no smi");
  a_smi_holds: assert property (o_smi_request && wr_gap > 8 |=> o_smi_request)
    else $error("smi dropped without a write");
  a_drive_late: assert property ($fell(o_io_data_oe_n) |-> $past(i_io_read_n, 2) == 1'b0)
    else $error("bus driven too early");
  a_drive_ends: assert property (!o_io_data_oe_n |-> rd_gap <= 5)
    else $error("bus driven without a read");
  a_data_steady: assert property (!o_io_data_oe_n && !$past(o_io_data_oe_n) |-> $stable(o_io_data))
    else $error("read data moved while driven");
endmodule

// ==== testbench/wsc_wake_src.sv ====
module wsc_wake_src (
  input wire logic i_clock, // System clock
  input wire logic [3:0] i_fire, // Raise: irq3, irq4, irq8, ring
  input wire logic i_wake, // Wake pulse from the block
  output logic [3:0] o_lines // Source lines, same order
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold = 0;
  initial o_lines = 4'h0;
  // hold until wake
  // A raised line stays high until wake, or drops after 16 cycles
  always @(posedge i_clock) begin
    if (i_fire != 4'h0) begin
      o_lines <= i_fire;
      hold <= 16;
    end else if (i_wake || hold == 1) begin
      o_lines <= 4'h0;
      hold <= 0;
    end else if (hold > 1) begin
      hold <= hold - 1;
    end
  end
endmodule

// ==== testbench/wsc_top_tb_top.sv ====
module wsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [9:0] addr;
  logic rd_n, wr_n, bhe_n, ext_n, batt_n, sr_n, asleep, tick, pmc, rel_en, oe_n, wake, smi, roe;
  logic [7:0] din, dout, rdata;
  logic [3:0] fire, lines;
  logic [1:0] dirq, wrange;
  logic [2:0] idle;
  logic [2:0][31:0] period;
  logic [9:0] tbl [3] = '{10'h1F1, 10'h3F7, 10'h103};
  int err_count = 0;
  int n_checks = 0;
  // Clock of 4 ns period
  always #2 clock = ~clock;
  wsc_top wsc_top_i (.i_clock(clock), .i_reset(reset), .i_io_addr(addr),
    .i_io_read_n(rd_n), .i_io_write_n(wr_n), .i_byte_high_n(bhe_n), .i_io_data(din),
    .o_io_data(dout), .o_io_data_oe_n(oe_n), .i_irq3(lines[0]), .i_irq4(lines[1]),
    .i_irq8(lines[2]), .i_irq6(dirq[1]), .i_irq14(dirq[0]), .i_external_trap_pin_n(ext_n),
    .i_battery_low_input_n(batt_n), .i_suspend_resume_input_n(sr_n),
    .i_ring_indicate(lines[3]), .i_system_asleep(asleep), .i_sleep_entry(1'b0),
    .i_power_mode_change(pmc), .i_tick_irq_request(tick), .i_interrupt_reload_enable(rel_en),
    .i_window_base(8'h40), .i_window_range(wrange), .i_idle_period(period), .o_wake(wake),
    .o_smi_request(smi), .o_device_idle(idle));
  wsc_wake_src wsc_wake_src_i (.i_clock(clock), .i_fire(fire), .i_wake(wake), .o_lines(lines));
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle: strobe low 4 cycles, sample, release, rest 5
  task automatic io(logic [9:0] a, logic w, logic [7:0] d);
    addr = a;
    din = d;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    cyc(4);
    rdata = dout;
    roe = oe_n;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cyc(5);
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    io(10'h022, 1'b1, idx);
    io(10'h023, 1'b1, d);
  endtask
  task automatic rd(logic [7:0] idx, logic [7:0] exp, string what);
    io(10'h022, 1'b1, idx);
    io(10'h023, 1'b0, 8'h00);
    chk(what, rdata, exp);
  endtask
  task automatic t_regs();
    logic [7:0] idx [6] = '{8'h08, 8'h09, 8'h40, 8'h41, 8'h42, 8'h43};
    foreach (idx[i]) rd(idx[i], 8'h00, "reset value");
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'hFF, "mask all bits");
    wr(8'h08, 8'h00);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, 8'hFF, "boot location");
    io(10'h022, 1'b1, 8'h30);
    io(10'h023, 1'b0, 8'h00);
    chk("unmapped drive", {7'h00, roe}, 8'h01);
    $display("test regs done");
  endtask
  task automatic fire_src(int k, output logic woke);
    fire = 4'(1 << k);
    cyc(1);
    fire = 4'h0;
    woke = 1'b0;
    repeat (12) begin
      if (wake === 1'b1) woke = 1'b1;
      cyc(1);
    end
  endtask
  task automatic t_wake();
    logic woke;
    asleep = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'h08, 8'(1 << (k + 2)));
      fire_src(k, woke);
      chk("masked wake", {7'h00, woke}, 8'h00);
      wr(8'h08, 8'h00);
      fire_src(k, woke);
      chk("wake", {7'h00, woke}, 8'h01);
      rd(8'h09, 8'(1 << (k + 2)), "wake cause");
      wr(8'h09, 8'h00);
      rd(8'h09, 8'h00, "cause cleared");
    end
    asleep = 1'b0;
    $display("test wake done");
  endtask
  task automatic t_timed();
    for (int j = 0; j < 3; j++) begin
      wr(8'h41, 8'(1 << j));
      io(tbl[j], 1'b0, 8'h00);
      chk("trap smi", {7'h00, smi}, 8'h01);
      rd(8'h43, 8'(1 << j), "trap flag");
      rd(8'h40, 8'(1 << j), "latch set");
      rd(8'h42, 8'h07, "capture read");
      wr(8'h43, 8'h5A);
      chk("flags cleared", {7'h00, smi}, 8'h00);
      io(tbl[j], 1'b0, 8'h00);
      chk("latched no trap", {7'h00, smi}, 8'h00);
      wr(8'h40, 8'h07);
      rd(8'h40, 8'(1 << j), "write one keeps");
      wr(8'h40, 8'h00);
      io(tbl[j], 1'b0, 8'h00);
      chk("rearmed trap", {7'h00, smi}, 8'h01);
      wr(8'h43, 8'h00);
      wr(8'h41, 8'h00);
      wr(8'h40, 8'h00);
    end
    $display("test timed done");
  endtask
  task automatic t_idle();
    for (int j = 0; j < 3; j++) begin
      io(tbl[j], 1'b0, 8'h00);
      cyc(45);
      chk("idle expired", {7'h00, idle[j]}, 8'h01);
      io(tbl[j], 1'b0, 8'h00);
      chk("access reload", {7'h00, idle[j]}, 8'h00);
      cyc(45);
      // Only the two disk timers have an interrupt reload
      for (int e = 0; e < 2 && j < 2; e++) begin
        rel_en = e[0];
        dirq[j] = 1'b1;
        cyc(4);
        dirq[j] = 1'b0;
        cyc(2);
        chk("irq reload", {7'h00, idle[j]}, 8'(1 - e));
      end
      rel_en = 1'b0;
    end
    $display("test idle done");
  endtask
  task automatic t_untimed();
    wr(8'h41, 8'h18);
    bhe_n = 1'b0;
    io(10'h060, 1'b1, 8'h00);
    bhe_n = 1'b1;
    rd(8'h43, 8'h08, "keyboard flag");
    rd(8'h42, 8'h08, "capture write");
    io(10'h071, 1'b0, 8'h00);
    rd(8'h43, 8'h18, "clock range flag");
    wr(8'h43, 8'h00);
    io(10'h064, 1'b0, 8'h00);
    chk("every access", {7'h00, smi}, 8'h01);
    wr(8'h43, 8'h00);
    // Widest window size reaches 11Ch
    wrange = 2'h3;
    wr(8'h41, 8'h04);
    io(10'h11C, 1'b0, 8'h00);
    rd(8'h43, 8'h04, "wide window flag");
    wrange = 2'h0;
    wr(8'h43, 8'h00);
    wr(8'h41, 8'h00);
    $display("test untimed done");
  endtask
  task automatic t_events();
    for (int k = 0; k < 4; k++) begin
      if (k == 0) tick = 1'b1;
      else if (k == 1) pmc = 1'b1;
      else if (k == 2) batt_n = 1'b0;
      else sr_n = 1'b0;
      cyc(1);
      tick = 1'b0;
      pmc = 1'b0;
      cyc(3);
      batt_n = 1'b1;
      sr_n = 1'b1;
      cyc(4);
      chk("event smi", {7'h00, smi}, 8'h01);
      rd(8'h43, (k == 0) ? 8'h40 : 8'h20, "event flag");
      wr(8'h43, 8'h00);
      chk("smi released", {7'h00, smi}, 8'h00);
    end
    ext_n = 1'b0;
    cyc(4);
    ext_n = 1'b1;
    cyc(4);
    rd(8'h42, 8'h03, "pin capture");
    rd(8'h43, 8'h00, "pin no flag");
    $display("test events done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    addr = 10'h000;
    din = 8'h00;
    {rd_n, wr_n, bhe_n, ext_n, batt_n, sr_n} = 6'h3F;
    {asleep, tick, pmc, rel_en} = 4'h0;
    fire = 4'h0;
    dirq = 2'h0;
    wrange = 2'h0;
    period = {3{32'd40}};
    repeat (4) @(posedge clock);
    #1;
    reset = 1'b0;
    cyc(3);
    t_regs();
    t_wake();
    t_timed();
    t_idle();
    t_untimed();
    t_events();
    end_of_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    err_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
bind wsc_top wsc_top_chk wsc_top_chk_i (.i_clock(i_clock), .i_reset(i_reset),
  .i_io_read_n(i_io_read_n), .i_io_write_n(i_io_write_n),
  .i_tick_irq_request(i_tick_irq_request), .i_power_mode_change(i_power_mode_change),
  .i_system_asleep(i_system_asleep), .o_io_data(o_io_data), .o_io_data_oe_n(o_io_data_oe_n),
  .o_wake(o_wake), .o_smi_request(o_smi_request), .o_device_idle(o_device_idle));
